// ===== include/ifd_regs.vh
// Constants for the instruction format decoder: fields, encodings, timing
`ifndef IFD_REGS_VH
`define IFD_REGS_VH

// Word and field layout
`define IFD_WORD_W 14
`define IFD_OPC_HI 13
`define IFD_BYTE_OPC_LO 8
`define IFD_DEST_BIT 7
`define IFD_FILE_HI 6
`define IFD_FILE_LO 0
`define IFD_BIT_OPC_LO 10
`define IFD_BITNUM_HI 9
`define IFD_BITNUM_LO 7
`define IFD_K8_HI 7
`define IFD_K11_HI 10
`define IFD_K7_HI 6
`define IFD_K5_HI 4
`define IFD_K9_HI 8
`define IFD_PTRO_N_BIT 6
`define IFD_K6_HI 5
`define IFD_PTRI_N_BIT 2
`define IFD_MODE_HI 1

// Destination select values
`define IFD_DEST_ACC 1'b0
`define IFD_DEST_FILE 1'b1

// Instruction groups
`define IFD_CLS_BYTE 2'h0
`define IFD_CLS_BIT 2'h1
`define IFD_CLS_LIT 2'h2

// Word formats
`define IFD_FMT_BYTE 3'h0
`define IFD_FMT_BIT 3'h1
`define IFD_FMT_GEN 3'h2
`define IFD_FMT_ABS 3'h3
`define IFD_FMT_PAGE 3'h4
`define IFD_FMT_BANK 3'h5
`define IFD_FMT_REL 3'h6
`define IFD_FMT_PTR 3'h7

// Encodings: pattern and care mask; a zero mask bit is a don't-care
`define IFD_P_CALL 14'h2000
`define IFD_M_CALL 14'h3800
`define IFD_P_GOTO 14'h2800
`define IFD_M_GOTO 14'h3800
`define IFD_P_BRA 14'h3200
`define IFD_M_BRA 14'h3E00
`define IFD_P_PAGE 14'h3180
`define IFD_M_PAGE 14'h3F80
`define IFD_P_BANK 14'h0020
`define IFD_M_BANK 14'h3FE0
`define IFD_P_ADDP 14'h3100
`define IFD_M_ADDP 14'h3F80
`define IFD_P_PTRO 14'h3F00
`define IFD_M_PTRO 14'h3F00
`define IFD_P_PTRI 14'h0010
`define IFD_M_PTRI 14'h3FF0
`define IFD_P_RET 14'h0008
`define IFD_P_RETI 14'h0009
`define IFD_P_CALL_VIA_ACCUMULATOR 14'h000A
`define IFD_P_BRW 14'h000B
`define IFD_M_FULL 14'h3FFF
`define IFD_P_RETLIT 14'h3400
`define IFD_M_BYTEOP 14'h3F00
`define IFD_P_DECSZ 14'h0B00
`define IFD_P_INCSZ 14'h0F00
`define IFD_P_MOVWF 14'h0080
`define IFD_M_MOVWF 14'h3F80
`define IFD_M_BITOP 14'h3C00
`define IFD_P_BCLR 14'h1000
`define IFD_P_BSET 14'h1400
`define IFD_P_SKCLR 14'h1800
`define IFD_P_SKSET 14'h1C00

// Indirect access register addresses
`define IFD_INDF0 7'h00
`define IFD_INDF1 7'h01

// Timing
`define IFD_PHASES 4
`define IFD_PH_READ 2'h0
`define IFD_PH_WRITE 2'h3
`define IFD_PH_LAST 2'h3
`define IFD_CYC_ONE 2'h1
`define IFD_CYC_TWO 2'h2

`endif

// ===== src/ifd_phase_gen.v
// Oscillator phase counter: four oscillator cycles per instruction cycle
`timescale 1ns/1ps
module ifd_phase_gen
(
   input wire clk_in,
   input wire rst_n_in,
   output reg [1:0] phase_out,
   output wire last_out
);
`include "ifd_regs.vh"

   // Free running; every instruction cycle spans phases 0..3
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         phase_out <= 2'h0;
      else
         phase_out <= phase_out + 2'h1;
   end

   assign last_out = (phase_out == `IFD_PH_LAST);

endmodule

// ===== src/ifd_decoder.v
// Instruction format decoder with cycle sequencing and read-modify-write strobes
`timescale 1ns/1ps
// Behaviour
// - each instruction is one 14-bit word holding opcode and all operands
// - every word is classed byte-oriented, bit-oriented, or literal/control
// - instructions take one instruction cycle unless an exception applies
// - absolute call and call via accumulator take two cycles
// - return, return with literal and return from interrupt take two cycles
// - jumps, branches and taken skips take two cycles
// - indirect access while pointer addresses program memory adds one cycle
// - one instruction cycle is four oscillator cycles
// - a named file register is read, modified, then written, always read
// - destination bit 0 sends result to accumulator, 1 to file register
// - file address is seven bits, 0x00 to 0x7F in current bank
// - byte format: opcode 13..8, destination 7, file address 6..0
// - bit format: opcode 13..10, bit number 9..7, file address 6..0
// - general literal format: opcode 13..8, eight-bit immediate 7..0
// - absolute call and jump: opcode 13..11, eleven-bit target 10..0
// - page load: opcode 13..7, seven-bit immediate 6..0
// - bank load: opcode 13..5, five-bit bank number 4..0
// - relative branch: opcode 13..9, nine-bit offset 8..0
// - pointer offset: opcode 13..7, pointer 6, six-bit offset 5..0
// - pointer increment: opcode 13..3, pointer 2, two-bit mode 1..0
// - pointer number selects one of two pointers and indirect registers
// - don't-care bit positions are ignored, either value accepted
// - taken branch or skip lasts two cycles, second one a no-operation
module ifd_decoder
(
   input wire ref_clk_in,
   input wire reset_n_in,
   input wire [13:0] instr_word_in,
   input wire instr_valid_in,
   input wire skip_cond_in,
   input wire [1:0] ptr_msb_in,
   output reg instr_ready_out,
   output reg busy_out,
   output reg [1:0] class_out,
   output reg [2:0] format_out,
   output reg [6:0] opcode_out,
   output reg dest_sel_out,
   output reg [6:0] file_addr_out,
   output reg [2:0] bit_num_out,
   output reg [7:0] imm8_out,
   output reg [10:0] imm11_out,
   output reg [6:0] imm7_out,
   output reg [4:0] imm5_out,
   output reg [8:0] imm9_out,
   output reg [5:0] imm6_out,
   output reg ptr_num_out,
   output reg [1:0] ptr_mode_out,
   output reg [1:0] phase_out,
   output reg [1:0] cycle_idx_out,
   output reg [1:0] cycles_out,
   output reg nop_cycle_out,
   output reg file_read_out,
   output reg file_write_out,
   output reg acc_write_out,
   output reg done_out
);
`include "ifd_regs.vh"

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Masked match; cleared mask bits are don't-care positions
   function match;
      input [13:0] word;
      input [13:0] pat;
      input [13:0] msk;
      begin
         match = ((word & msk) == (pat & msk));
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   reg rst_meta_reg;
   reg rst_sync_reg;
   always @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator phase within the instruction cycle
   wire [1:0] phase;
   wire phase_last;
   ifd_phase_gen u_phase
   (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_sync_reg),
      .phase_out(phase),
      .last_out(phase_last)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Combinational decode of the incoming word
   wire [13:0] w = instr_word_in;
   wire is_call = match(w, `IFD_P_CALL, `IFD_M_CALL);
   wire is_goto = match(w, `IFD_P_GOTO, `IFD_M_GOTO);
   wire is_bra = match(w, `IFD_P_BRA, `IFD_M_BRA);
   wire is_page = match(w, `IFD_P_PAGE, `IFD_M_PAGE);
   wire is_bank = match(w, `IFD_P_BANK, `IFD_M_BANK);
   wire is_addp = match(w, `IFD_P_ADDP, `IFD_M_ADDP);
   wire is_ptro = match(w, `IFD_P_PTRO, `IFD_M_PTRO);
   wire is_ptri = match(w, `IFD_P_PTRI, `IFD_M_PTRI);
   wire is_call_via_accumulator = match(w, `IFD_P_CALL_VIA_ACCUMULATOR, `IFD_M_FULL);
   wire is_brw = match(w, `IFD_P_BRW, `IFD_M_FULL);
   wire is_ret = match(w, `IFD_P_RET, `IFD_M_FULL);
   wire is_reti = match(w, `IFD_P_RETI, `IFD_M_FULL);
   wire is_retlit = match(w, `IFD_P_RETLIT, `IFD_M_BYTEOP);
   wire is_bclr = match(w, `IFD_P_BCLR, `IFD_M_BITOP);
   wire is_bset = match(w, `IFD_P_BSET, `IFD_M_BITOP);
   wire is_skclr = match(w, `IFD_P_SKCLR, `IFD_M_BITOP);
   wire is_skset = match(w, `IFD_P_SKSET, `IFD_M_BITOP);
   wire is_decsz = match(w, `IFD_P_DECSZ, `IFD_M_BYTEOP);
   wire is_incsz = match(w, `IFD_P_INCSZ, `IFD_M_BYTEOP);
   wire is_movwf = match(w, `IFD_P_MOVWF, `IFD_M_MOVWF);

   // Byte group: the 00 space above the control block, move-to-file, plus the five
   // shift and carry ops that live in the 11 space
   wire [3:0] mid = w[11:8];
   wire hi_byte = (w[13:12] == 2'b11) && ((mid == 4'h5) || (mid == 4'h6) ||
                  (mid == 4'h7) || (mid == 4'hB) || (mid == 4'hD));
   wire is_byte = ((w[13:12] == 2'b00) && (mid != 4'h0)) || is_movwf || hi_byte;
   wire is_bit = (w[13:12] == 2'b01);

   reg [1:0] cls;
   reg [2:0] fmt;
   reg [6:0] opc;
   always @*
   begin
      cls = `IFD_CLS_LIT;
      fmt = `IFD_FMT_GEN;
      opc = {1'b0, w[13:8]};
      if (is_byte)
      begin
         cls = `IFD_CLS_BYTE;
         fmt = `IFD_FMT_BYTE;
         opc = {1'b0, w[13:`IFD_BYTE_OPC_LO]};
      end
      else if (is_bit)
      begin
         cls = `IFD_CLS_BIT;
         fmt = `IFD_FMT_BIT;
         opc = {3'h0, w[13:`IFD_BIT_OPC_LO]};
      end
      else if (is_call || is_goto)
      begin
         fmt = `IFD_FMT_ABS;
         opc = {4'h0, w[13:11]};
      end
      else if (is_page || is_addp)
      begin
         fmt = is_page ? `IFD_FMT_PAGE : `IFD_FMT_PTR;
         opc = w[13:7];
      end
      else if (is_ptro)
      begin
         fmt = `IFD_FMT_PTR;
         opc = w[13:7];
      end
      else if (is_bank)
      begin
         fmt = `IFD_FMT_BANK;
         opc = w[13:7];
      end
      else if (is_bra)
      begin
         fmt = `IFD_FMT_REL;
         opc = {2'h0, w[13:9]};
      end
      else if (is_ptri)
      begin
         fmt = `IFD_FMT_PTR;
         opc = w[13:7];
      end
   end

   // Pointer number: bit 6 for offset forms, bit 2 for increment forms
   wire ptr_n = is_ptri ? w[`IFD_PTRI_N_BIT] : w[`IFD_PTRO_N_BIT];

   // Indirect access through a pointer whose top bit selects program memory
   wire [6:0] faddr = w[`IFD_FILE_HI:`IFD_FILE_LO];
   wire names_indirect_access_register = (is_byte || is_bit) &&
                     ((faddr == `IFD_INDF0) || (faddr == `IFD_INDF1));
   wire indirect_access_register_prog = names_indirect_access_register && ptr_msb_in[faddr[0]];
   wire ptr_prog = (is_ptri || is_ptro) && ptr_msb_in[ptr_n];
   wire extra = indirect_access_register_prog || ptr_prog;

   // Fixed two-cycle flows; conditional skips extend only when taken
   wire flow2 = is_call || is_call_via_accumulator ||
                is_ret || is_retlit || is_reti ||
                is_goto || is_bra || is_brw;
   wire is_skip = is_skclr || is_skset || is_decsz || is_incsz;
   wire [1:0] base_cyc = flow2 ? `IFD_CYC_TWO : `IFD_CYC_ONE;
   wire [1:0] cyc_total = base_cyc + {1'b0, extra};

   // Write targets of file-addressed instructions
   wire d_bit = w[`IFD_DEST_BIT];
   wire wr_file = (is_byte && (d_bit == `IFD_DEST_FILE)) || is_bclr || is_bset;
   wire wr_acc = is_byte && (d_bit == `IFD_DEST_ACC);

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state
   reg state_reg;
   reg [1:0] cyc_reg;
   reg [1:0] total_reg;
   reg skip_reg;
   reg flow_reg;
   reg rmw_reg;
   reg wf_reg;
   reg wa_reg;

   // A word is taken at the last phase so its first cycle starts at phase 0;
   // this also lets words follow back to back with no bubble
   wire finishing = (state_reg == ST_RUN) && phase_last &&
                    (cyc_reg == total_reg - 2'h1) &&
                    !(skip_reg && (cyc_reg == 2'h0) && skip_cond_in);
   wire can_take = phase_last && ((state_reg == ST_IDLE) || finishing);
   wire take = can_take && instr_valid_in;

   reg state_next;
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (take)
               state_next = ST_RUN;
         end
         ST_RUN:
         begin
            if (finishing && !take)
               state_next = ST_IDLE;
         end
         default:
            state_next = ST_IDLE;
      endcase
   end

   // Cycle count and skip extension
   always @(posedge ref_clk_in or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         state_reg <= ST_IDLE;
         cyc_reg <= 2'h0;
         total_reg <= `IFD_CYC_ONE;
         skip_reg <= 1'b0;
         flow_reg <= 1'b0;
         rmw_reg <= 1'b0;
         wf_reg <= 1'b0;
         wa_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (take)
         begin
            cyc_reg <= 2'h0;
            total_reg <= cyc_total;
            skip_reg <= is_skip;
            flow_reg <= flow2;
            rmw_reg <= is_byte || is_bit;
            wf_reg <= wr_file;
            wa_reg <= wr_acc;
         end
         else if ((state_reg == ST_RUN) && phase_last)
         begin
            cyc_reg <= cyc_reg + 2'h1;
            // Taken skip: one more cycle, run as a no-operation
            if (skip_reg && (cyc_reg == 2'h0) && skip_cond_in)
            begin
               total_reg <= total_reg + 2'h1;
               flow_reg <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered fields, latched when a word is taken; cycles_out also grows by one on a taken skip
   always @(posedge ref_clk_in or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         class_out <= `IFD_CLS_LIT;
         format_out <= `IFD_FMT_GEN;
         opcode_out <= 7'h00;
         dest_sel_out <= `IFD_DEST_FILE;
         file_addr_out <= 7'h00;
         bit_num_out <= 3'h0;
         imm8_out <= 8'h00;
         imm11_out <= 11'h000;
         imm7_out <= 7'h00;
         imm5_out <= 5'h00;
         imm9_out <= 9'h000;
         imm6_out <= 6'h00;
         ptr_num_out <= 1'b0;
         ptr_mode_out <= 2'h0;
         cycles_out <= `IFD_CYC_ONE;
      end
      else
      begin
         if (take)
         begin
            class_out <= cls;
            format_out <= fmt;
            opcode_out <= opc;
            dest_sel_out <= d_bit;
            file_addr_out <= faddr;
            bit_num_out <= w[`IFD_BITNUM_HI:`IFD_BITNUM_LO];
            imm8_out <= w[`IFD_K8_HI:0];
            imm11_out <= w[`IFD_K11_HI:0];
            imm7_out <= w[`IFD_K7_HI:0];
            imm5_out <= w[`IFD_K5_HI:0];
            imm9_out <= w[`IFD_K9_HI:0];
            imm6_out <= w[`IFD_K6_HI:0];
            ptr_num_out <= ptr_n;
            ptr_mode_out <= w[`IFD_MODE_HI:0];
            cycles_out <= cyc_total;
         end
         else if ((state_reg == ST_RUN) && phase_last && skip_reg &&
                  (cyc_reg == 2'h0) && skip_cond_in)
            cycles_out <= total_reg + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status and read-modify-write strobes, one oscillator cycle late
   wire run_now = (state_reg == ST_RUN);
   always @(posedge ref_clk_in or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         instr_ready_out <= 1'b0;
         busy_out <= 1'b0;
         phase_out <= 2'h0;
         cycle_idx_out <= 2'h0;
         nop_cycle_out <= 1'b0;
         file_read_out <= 1'b0;
         file_write_out <= 1'b0;
         acc_write_out <= 1'b0;
         done_out <= 1'b0;
      end
      else
      begin
         // Ready shows the take window of the coming edge one cycle early
         instr_ready_out <= (phase == 2'h2) &&
                            ((state_reg == ST_IDLE) || (cyc_reg == total_reg - 2'h1));
         busy_out <= run_now;
         phase_out <= phase;
         cycle_idx_out <= cyc_reg;
         nop_cycle_out <= run_now && flow_reg && (cyc_reg != 2'h0);
         // Read even for write-only ops such as clear or move-to-file
         file_read_out <= run_now && rmw_reg && (cyc_reg == 2'h0) &&
                          (phase == `IFD_PH_READ);
         file_write_out <= run_now && wf_reg && (cyc_reg == 2'h0) &&
                           (phase == `IFD_PH_WRITE);
         acc_write_out <= run_now && wa_reg && (cyc_reg == 2'h0) &&
                          (phase == `IFD_PH_WRITE);
         done_out <= finishing;
      end
   end

endmodule

// ===== dv/ifd_decoder_properties.sv
// Port assertions for the instruction format decoder
`timescale 1ns/1ps
`include "ifd_regs.vh"
////////////////////////////////////////
module ifd_decoder_properties
(
   input wire ref_clk_in,
   input wire reset_n_in,
   input wire busy_out,
   input wire [1:0] class_out,
   input wire [2:0] format_out,
   input wire dest_sel_out,
   input wire [1:0] phase_out,
   input wire [1:0] cycle_idx_out,
   input wire nop_cycle_out,
   input wire file_read_out,
   input wire file_write_out,
   input wire acc_write_out,
   input wire done_out
);
   reg [2:0] settle_reg;
   reg rd_seen_reg;
   reg dsel_seen_reg;
   reg [1:0] cls_seen_reg;
   reg [2:0] fmt_seen_reg;
   // Phase checks wait out the two reset flops; a read marks the current instruction
   // Fields are kept from the read, as a back-to-back take renews them with the store
   always @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         settle_reg <= 3'h0;
         rd_seen_reg <= 1'b0;
         dsel_seen_reg <= 1'b1;
         cls_seen_reg <= 2'h2;
         fmt_seen_reg <= 3'h2;
      end
      else
      begin
         if (settle_reg != 3'h7)
            settle_reg <= settle_reg + 3'h1;
         if (file_read_out)
         begin
            rd_seen_reg <= 1'b1;
            dsel_seen_reg <= dest_sel_out;
            cls_seen_reg <= class_out;
            fmt_seen_reg <= format_out;
         end
         else if (done_out)
            rd_seen_reg <= 1'b0;
      end
   end
   default clocking dc @(posedge ref_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   // Phase 2 must be followed by the last phase and then a fresh cycle
   sequence s_turn;
      phase_out == 2'h3 ##1 phase_out == 2'h0;
   endsequence
   a_phase_turn: assert property ((settle_reg == 3'h7 && phase_out == 2'h2) |=> s_turn)
      else $error("phase did not wrap after two");
   a_phase_step: assert property (settle_reg == 3'h7 |=> phase_out == $past(phase_out) + 2'h1)
      else $error("phase did not advance by one");
   a_done_single: assert property (done_out |=> !done_out)
      else $error("done held longer than one cycle");
   a_busy_done: assert property (done_out |-> busy_out)
      else $error("done without a running instruction");
   a_rmw_order: assert property ((file_write_out || acc_write_out) |-> rd_seen_reg)
      else $error("result stored without a prior read");
   a_dest_acc: assert property (acc_write_out |-> !dsel_seen_reg && cls_seen_reg == `IFD_CLS_BYTE)
      else $error("accumulator written with wrong destination");
   a_dest_file: assert property (file_write_out && fmt_seen_reg == `IFD_FMT_BYTE |-> dsel_seen_reg)
      else $error("file written with accumulator destination");
   a_one_target: assert property (!(file_write_out && acc_write_out))
      else $error("both result targets written");
   a_nop_late: assert property (nop_cycle_out |-> cycle_idx_out != 2'h0)
      else $error("no-operation marked in first cycle");
   a_class_fmt: assert property (class_out == ((format_out == `IFD_FMT_BYTE) ? `IFD_CLS_BYTE :
      (format_out == `IFD_FMT_BIT) ? `IFD_CLS_BIT : `IFD_CLS_LIT))
      else $error("group disagrees with format");
endmodule
////////////////////////////////////////
bind ifd_decoder ifd_decoder_properties i_ifd_decoder_properties (.*);

// ===== dv/ifd_prog_mem_model.sv
// Program memory and datapath model feeding the decoder
`timescale 1ns/1ps
module ifd_prog_mem_model
(
   input wire clk_in,
   input wire rst_n_in,
   input wire ready_in,
   input wire done_in,
   output logic [13:0] word_out = 14'h0000,
   output logic valid_out = 1'b0,
   output logic skip_out = 1'b0,
   output logic [1:0] ptr_out = 2'h0,
   output logic taken_out = 1'b0
);
   // Entry: skip op, skip true, pointer top bits, word
   logic [17:0] q[$];
   logic [17:0] cur;
   logic hold = 1'b0;
   logic [2:0] gap = 3'h0;
   task push(input logic [17:0] e);
      q.push_back(e);
   endtask
   // Word held until taken; after a skip op the next word waits for done
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         valid_out <= 1'b0;
         taken_out <= 1'b0;
         hold <= 1'b0;
      end
      else
      begin
         taken_out <= 1'b0;
         if (gap != 3'h0)
            gap <= gap - 3'h1;
         else if (done_in)
            hold <= 1'b0;
         if (valid_out && ready_in)
         begin
            taken_out <= 1'b1;
            skip_out <= cur[16];
            if (cur[17])
            begin
               hold <= 1'b1;
               gap <= 3'h3;
            end
         end
         if ((!valid_out || ready_in) && !hold && !(valid_out && ready_in && cur[17])
            && q.size() > 0)
         begin
            cur = q.pop_front();
            valid_out <= 1'b1;
            word_out <= cur[13:0];
            ptr_out <= cur[15:14];
         end
         else if (valid_out && ready_in)
         begin
            // Released lines show the inverse, never the stale word
            valid_out <= 1'b0;
            word_out <= ~word_out;
            ptr_out <= ~ptr_out;
         end
      end
   end
endmodule

// ===== dv/tb.sv
// Self-checking bench for the instruction format decoder
`timescale 1ns/1ps
module tb;
   logic ref_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [13:0] instr_word_in;
   logic instr_valid_in, skip_cond_in, taken;
   logic [1:0] ptr_msb_in, class_out, ptr_mode_out, phase_out, cycle_idx_out, cycles_out;
   logic instr_ready_out, busy_out, dest_sel_out, ptr_num_out, nop_cycle_out, done_out;
   logic file_read_out, file_write_out, acc_write_out;
   logic [2:0] format_out, bit_num_out;
   logic [6:0] opcode_out, file_addr_out, imm7_out;
   logic [7:0] imm8_out;
   logic [10:0] imm11_out;
   logic [4:0] imm5_out;
   logic [8:0] imm9_out;
   logic [5:0] imm6_out;
   // Kind table: pattern, free bits, group, format (9 unchecked), cycles, opcode low bit
   int pat[17] = '{14'h0700, 14'h1400, 14'h1C00, 14'h0B00, 14'h3000, 14'h2000, 14'h2800,
      14'h3200, 14'h3180, 14'h0020, 14'h3F00, 14'h0010, 14'h0008, 14'h0009, 14'h000A,
      14'h000B, 14'h3400};
   int msk[17] = '{14'h00FF, 14'h03FF, 14'h03FF, 14'h00FF, 14'h00FF, 14'h07FF, 14'h07FF,
      14'h01FF, 14'h007F, 14'h001F, 14'h00FF, 14'h0007, 0, 0, 0, 0, 14'h00FF};
   int cls[17] = '{0, 1, 1, 0, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2};
   int fmt[17] = '{0, 1, 1, 0, 2, 3, 3, 6, 4, 5, 7, 7, 9, 9, 9, 9, 2};
   int bas[17] = '{1, 1, 1, 1, 1, 2, 2, 2, 1, 1, 1, 1, 2, 2, 2, 2, 2};
   int opl[17] = '{8, 10, 10, 8, 8, 11, 11, 9, 7, 0, 7, 0, 0, 0, 0, 0, 8};
   int kq[$];
   logic [17:0] eq[$];
   int due_q[$];
   int nq[$];
   int mismatches = 0;
   int n_tests = 0;
   int cyc = 0;
   int k, n, i, r, m;
   logic [17:0] e;
   logic [13:0] w;
   logic pend = 1'b0;

   ifd_decoder i_ifd_decoder (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
      .instr_word_in(instr_word_in), .instr_valid_in(instr_valid_in),
      .skip_cond_in(skip_cond_in), .ptr_msb_in(ptr_msb_in),
      .instr_ready_out(instr_ready_out), .busy_out(busy_out), .class_out(class_out),
      .format_out(format_out), .opcode_out(opcode_out), .dest_sel_out(dest_sel_out),
      .file_addr_out(file_addr_out), .bit_num_out(bit_num_out), .imm8_out(imm8_out),
      .imm11_out(imm11_out), .imm7_out(imm7_out), .imm5_out(imm5_out),
      .imm9_out(imm9_out), .imm6_out(imm6_out), .ptr_num_out(ptr_num_out),
      .ptr_mode_out(ptr_mode_out), .phase_out(phase_out), .cycle_idx_out(cycle_idx_out),
      .cycles_out(cycles_out), .nop_cycle_out(nop_cycle_out),
      .file_read_out(file_read_out), .file_write_out(file_write_out),
      .acc_write_out(acc_write_out), .done_out(done_out));
   ifd_prog_mem_model i_ifd_prog_mem_model (.clk_in(ref_clk_in), .rst_n_in(reset_n_in),
      .ready_in(instr_ready_out), .done_in(done_out), .word_out(instr_word_in),
      .valid_out(instr_valid_in), .skip_out(skip_cond_in), .ptr_out(ptr_msb_in),
      .taken_out(taken));
   ////////////////////////////////////////
   task chk_field(input string nm, input logic [63:0] ex, input logic [63:0] ac);
      n_tests++;
      if (ex !== ac)
      begin
         mismatches++;
         $display("[ERR] %s expected %0h seen %0h", nm, ex, ac);
      end
   endtask
   task chk_count(input string nm, input int ex, input int ac);
      n_tests++;
      if (ex != ac)
      begin
         mismatches++;
         $display("[ERR] %s expected %0d seen %0d", nm, ex, ac);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Random operands; half the file ops aim at the indirect slots
   task send(input int kk);
      logic [17:0] en;
      en[13:0] = 14'(pat[kk] | ($urandom & msk[kk]));
      if (kk <= 3 && $urandom % 2)
         en[6:1] = 6'h00;
      en[15:14] = 2'($urandom);
      en[16] = 1'($urandom);
      en[17] = (kk == 2 || kk == 3);
      kq.push_back(kk);
      eq.push_back(en);
      i_ifd_prog_mem_model.push(en);
   endtask
   task drain;
      r = 0;
      while ((kq.size() > 0 || due_q.size() > 0 || pend) && r < 5000)
      begin
         @(posedge ref_clk_in);
         r++;
      end
      // Work still outstanding at the limit is a stall and counts as a failure
      if (kq.size() > 0 || due_q.size() > 0)
         mismatches++;
   endtask
   ////////////////////////////////////////
   // Clock at 100 MHz
   initial
   begin
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   // Reference model: expected cycle count and done edge for every taken word
   always @(posedge ref_clk_in)
   begin
      cyc <= cyc + 1;
      if (taken === 1'b1)
      begin
         k = kq.pop_front();
         e = eq.pop_front();
         w = e[13:0];
         n = bas[k];
         if (e[17] && e[16])
            n++;
         if (k <= 3 && w[6:1] == 6'h00 && e[14 + w[0]])
            n++;
         if ((k == 10 || k == 11) && e[14 + ((k == 10) ? w[6] : w[2])])
            n++;
         due_q.push_back(cyc + 4 * n);
         nq.push_back(e[17] ? n : 0);
         pend = 1'b1;
      end
      // Skip ops hold the next word back, so the final count still stands at done
      if (done_out === 1'b1)
      begin
         chk_count("done_edge", due_q.pop_front(), cyc);
         m = nq.pop_front();
         if (m != 0)
            chk_count("skip_cycles", m, cycles_out);
      end
   end
   // Fields are compared once settled, one cycle after the take
   always @(negedge ref_clk_in)
   begin
      if (pend)
      begin
         pend = 1'b0;
         chk_field("class", cls[k], class_out);
         if (fmt[k] != 9)
            chk_field("format", fmt[k], format_out);
         if (opl[k] != 0)
            chk_field("opcode", w >> opl[k], opcode_out);
         chk_field("fields", {w[7], w[6:0], w[9:7], w[7:0], w[10:0], w[6:0], w[4:0], w[8:0],
            w[5:0], (k == 11) ? w[2] : w[6], w[1:0]}, {dest_sel_out, file_addr_out,
            bit_num_out, imm8_out, imm11_out, imm7_out, imm5_out, imm9_out, imm6_out,
            ptr_num_out, ptr_mode_out});
         if (!e[17])
            chk_field("cycles", n, cycles_out);
      end
   end
   // Main sequence: every kind three times, then a reset once drained, then three more words
   initial
   begin
      r = $urandom(8);
      repeat (8) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      for (i = 0; i < 51; i++)
         send(i % 17);
      drain();
      @(posedge ref_clk_in);
      reset_n_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk_field("reset_vals", {2'h2, 3'h2, 1'b1, 2'h1, 1'b0},
         {class_out, format_out, dest_sel_out, cycles_out, done_out});
      @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      send(5);
      send(2);
      send(10);
      drain();
      finish_test();
   end
   // Watchdog well beyond the expected run of under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge ref_clk_in);
      mismatches++;
      finish_test();
   end
endmodule
